// ==== inc/acr_pkg.sv ====
// Purpose: Shared constants for the converter configuration register bank.
// Assumes: 12-bit data bus, two 10-bit configuration words.
// Notes: Field positions are bit indices inside a configuration word.
`default_nettype none
package acr_pkg;

  // ****************************************
  // Bus and word sizes
  // ****************************************
  localparam int DATA_W = 12;
  localparam int WORD_W = 10;

  // ****************************************
  // Register select codes on the top two data lines
  // ****************************************
  localparam logic [1:0] SEL_MODE = 2'h0;
  localparam logic [1:0] SEL_IFACE = 2'h1;

  // ****************************************
  // Mode word field positions
  // ****************************************
  localparam int MODE_REF_BIT = 0;
  localparam int MODE_SLEEP_BIT = 2;
  localparam int MODE_PICK_LO = 3;
  localparam int MODE_PAIR_LO = 5;
  localparam int MODE_SCAN_BIT = 7;
  localparam int MODE_PROBE_LO = 8;

  // ****************************************
  // Interface word field positions
  // ****************************************
  localparam int IF_FULL_RST_BIT = 0;
  localparam int IF_SOFT_BIT = 1;
  localparam int IF_STROBE_BIT = 6;
  localparam int IF_FORMAT_BIT = 7;
  localparam int IF_OFFSET_BIT = 8;
  localparam int IF_ECHO_BIT = 9;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [9:0] MODE_RST = 10'h020;
  localparam logic [9:0] IFACE_RST = 10'h000;
  // Self-clearing action bits are never stored
  localparam logic [9:0] IFACE_STORE_MASK = 10'h3fc;

  // ****************************************
  // Output codes
  // ****************************************
  localparam logic [11:0] CODE_TOP = 12'hfff;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_BOTTOM = 12'h000;
  localparam logic [11:0] SIGN_FLIP = 12'h800;

  typedef enum logic [1:0] {
    PROBE_NORMAL = 2'h0,
    PROBE_TOP = 2'h1,
    PROBE_MID = 2'h2,
    PROBE_BOTTOM = 2'h3
  } acr_probe_t;

endpackage
`default_nettype wire

// ==== logic/acr_bank.sv ====
// Purpose: Configuration register bank and output code formatter of the converter.
// Assumes: Bus pins are asynchronous to clk; converter core codes arrive on clk.
// Notes: Pin data is captured at the end of a write strobe, after two flip-flops.
`timescale 1ns/10ps
`default_nettype none
module acr_bank import acr_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host bus pins
  input wire logic cs0_n,
  input wire logic cs1,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [11:0] data_in,
  output logic [11:0] data_out,
  output logic data_oe,
  // Converter core result
  input wire logic [11:0] raw_code,
  input wire logic raw_valid,
  output logic [11:0] sample_out,
  output logic sample_valid,
  // Mode word fields
  output logic ref_ext,
  output logic sleep_ctl,
  output logic input_pick_lo,
  output logic input_pick_hi,
  output logic pair_count_lo,
  output logic pair_count_hi,
  output logic autoscan_en,
  output logic probe_volt_sel_lo,
  output logic probe_volt_sel_hi,
  // Interface word fields
  output logic config_echo_en,
  output logic offset_en,
  output logic code_format_sel,
  output logic strobe_style,
  output logic soft_clear
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [14:0] pin_meta_r;
  logic [14:0] pin_sync_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_r <= 15'h7fff;
      pin_sync_r <= 15'h7fff;
    end else begin
      pin_meta_r <= {cs0_n, cs1, wr_n, data_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic cs0_n_s;
  logic cs1_s;
  logic wr_n_s;
  logic [11:0] data_s;
  logic rd_meta_r;
  logic rd_n_s;

  assign {cs0_n_s, cs1_s, wr_n_s, data_s} = pin_sync_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_meta_r <= 1'b1;
      rd_n_s <= 1'b1;
    end else begin
      rd_meta_r <= rd_n;
      rd_n_s <= rd_meta_r;
    end
  end

  // ****************************************
  // Strobe decode
  // ****************************************
  logic [9:0] mode_r;
  logic [9:0] iface_r;
  logic sel_s;
  logic strobe_s;
  logic strobe_prev_r;
  logic wr_evt;
  logic rd_act;

  assign sel_s = !cs0_n_s && cs1_s;
  // In read/write style the read pin strobes and the write pin gives direction
  assign strobe_s = iface_r[IF_STROBE_BIT] ? rd_n_s : wr_n_s;
  // Data is taken at the trailing edge, when the host has settled it
  assign wr_evt = sel_s && strobe_s && !strobe_prev_r
                  && (!iface_r[IF_STROBE_BIT] || !wr_n_s);
  assign rd_act = sel_s && !rd_n_s && (!iface_r[IF_STROBE_BIT] || wr_n_s);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_prev_r <= 1'b1;
    end else begin
      strobe_prev_r <= strobe_s;
    end
  end

  // ****************************************
  // Configuration words
  // ****************************************
  logic [1:0] wsel;
  logic full_rst_req;

  assign wsel = data_s[11:10];
  assign full_rst_req = wr_evt && (wsel == SEL_IFACE) && data_s[IF_FULL_RST_BIT];

  // Two words only; sleep never blocks writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Reset values of all mode fields
      mode_r <= MODE_RST;
    end else if (full_rst_req) begin
      mode_r <= MODE_RST;
    end else if (wr_evt && wsel == SEL_MODE) begin
      // Select 00 loads the mode word
      mode_r <= data_s[9:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      iface_r <= IFACE_RST;
    end else if (full_rst_req) begin
      iface_r <= IFACE_RST;
    end else if (wr_evt && wsel == SEL_IFACE) begin
      iface_r <= data_s[9:0] & IFACE_STORE_MASK;
    end
  end
  // Codes 10 and 11 fall through both processes untouched

  // Soft reset keeps the mode word, still loads the rest of the interface write, pulses the pipeline clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      soft_clear <= 1'b0;
    end else begin
      soft_clear <= wr_evt && (wsel == SEL_IFACE)
                    && (data_s[IF_SOFT_BIT] || data_s[IF_FULL_RST_BIT]);
    end
  end

  // ****************************************
  // Field outputs
  // ****************************************
  // Fields driven straight from the words
  assign ref_ext = mode_r[MODE_REF_BIT];
  assign sleep_ctl = mode_r[MODE_SLEEP_BIT];
  assign input_pick_lo = mode_r[MODE_PICK_LO];
  assign input_pick_hi = mode_r[MODE_PICK_LO + 1];
  assign pair_count_lo = mode_r[MODE_PAIR_LO];
  assign pair_count_hi = mode_r[MODE_PAIR_LO + 1];
  assign autoscan_en = mode_r[MODE_SCAN_BIT];
  assign probe_volt_sel_lo = mode_r[MODE_PROBE_LO];
  assign probe_volt_sel_hi = mode_r[MODE_PROBE_LO + 1];
  assign config_echo_en = iface_r[IF_ECHO_BIT];
  assign offset_en = iface_r[IF_OFFSET_BIT];
  assign code_format_sel = iface_r[IF_FORMAT_BIT];
  assign strobe_style = iface_r[IF_STROBE_BIT];

  // ****************************************
  // Output code formatting
  // ****************************************
  acr_probe_t probe;
  logic [11:0] bin_code;
  logic [11:0] sample_r;
  logic sample_vld_r;

  assign probe = acr_probe_t'(mode_r[MODE_PROBE_LO +: 2]);

  // Test voltages replace the converted code
  always_comb begin
    unique case (probe)
      PROBE_NORMAL: bin_code = raw_code;
      PROBE_TOP: bin_code = CODE_TOP;
      PROBE_MID: bin_code = CODE_MID;
      PROBE_BOTTOM: bin_code = CODE_BOTTOM;
    endcase
  end

  // Twos complement is offset binary with the sign bit flipped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_r <= CODE_BOTTOM;
      sample_vld_r <= 1'b0;
    end else begin
      sample_vld_r <= raw_valid;
      if (raw_valid) begin
        sample_r <= iface_r[IF_FORMAT_BIT] ? (bin_code ^ SIGN_FLIP) : bin_code;
      end
    end
  end

  assign sample_out = sample_r;
  assign sample_valid = sample_vld_r;

  // ****************************************
  // Read path
  // ****************************************
  logic [11:0] dout_r;
  logic oe_r;
  logic echo_ptr_r;
  logic rd_prev_r;

  // Echo alternates the two words, each tagged with its select code
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_prev_r <= 1'b0;
      echo_ptr_r <= 1'b0;
    end else begin
      rd_prev_r <= rd_act;
      if (!iface_r[IF_ECHO_BIT]) begin
        echo_ptr_r <= 1'b0;
      end else if (rd_prev_r && !rd_act) begin
        echo_ptr_r <= !echo_ptr_r;
      end
    end
  end

  // Reads are served regardless of sleep
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dout_r <= 12'h000;
      oe_r <= 1'b0;
    end else begin
      oe_r <= rd_act;
      if (iface_r[IF_ECHO_BIT]) begin
        dout_r <= echo_ptr_r ? {SEL_IFACE, iface_r} : {SEL_MODE, mode_r};
      end else begin
        dout_r <= sample_r;
      end
    end
  end

  assign data_out = dout_r;
  assign data_oe = oe_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence mode_wr_s;
    wr_evt && wsel == SEL_MODE;
  endsequence

  sequence resv_wr_s;
    wr_evt && wsel[1];
  endsequence

  sequence sleep_rd_s;
    mode_r[MODE_SLEEP_BIT] && rd_act ##1 rd_act;
  endsequence

  chk_mode_word_load: assert property (
    mode_wr_s |=> mode_r == $past(data_s[9:0]))
    else $error("mode word not loaded from data lines");

  chk_iface_word_load: assert property (
    wr_evt && wsel == SEL_IFACE && !data_s[IF_FULL_RST_BIT]
    |=> iface_r == ($past(data_s[9:0]) & IFACE_STORE_MASK))
    else $error("interface word not loaded");

  chk_resv_sel_ignored: assert property (
    resv_wr_s |=> $stable(mode_r) && $stable(iface_r))
    else $error("reserved select changed a word");

  chk_full_reset_vals: assert property (
    full_rst_req |=> mode_r == MODE_RST && iface_r == IFACE_RST)
    else $error("full reset did not restore words");

  chk_binary_pass: assert property (
    raw_valid && probe == PROBE_NORMAL && !iface_r[IF_FORMAT_BIT]
    |=> sample_out == $past(raw_code) && sample_valid)
    else $error("binary code not passed through");

  chk_twos_flip: assert property (
    raw_valid && probe == PROBE_NORMAL && iface_r[IF_FORMAT_BIT]
    |=> sample_out == ($past(raw_code) ^ SIGN_FLIP))
    else $error("twos complement code wrong");

  chk_probe_top_code: assert property (
    raw_valid && probe == PROBE_TOP && !iface_r[IF_FORMAT_BIT]
    |=> sample_out == CODE_TOP)
    else $error("top test voltage code wrong");

  chk_probe_mid_twos: assert property (
    raw_valid && probe == PROBE_MID && iface_r[IF_FORMAT_BIT]
    |=> sample_out == 12'h000)
    else $error("mid test voltage twos code wrong");

  chk_sleep_read_serve: assert property (
    sleep_rd_s |-> data_oe)
    else $error("read not served during sleep");

  chk_soft_clear_pulse: assert property (
    soft_clear |=> !soft_clear)
    else $error("soft clear held longer than one cycle");

endmodule // acr_bank
`default_nettype wire

// ==== bench/acr_host.sv ====
// Purpose: Host processor model driving the converter's parallel bus pins.
// Assumes: Pins are sampled through two flip-flops; strobes held several clocks.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none
module acr_host (
  // Clock and answer
  input wire logic clk,
  input wire logic [11:0] data_out,
  input wire logic data_oe,
  // Bus pins
  output logic cs0_n,
  output logic cs1,
  output logic wr_n,
  output logic rd_n,
  output logic [11:0] data_in
);
  initial begin
    cs0_n = 1'b1;
    cs1 = 1'b0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data_in = 12'hfff;
  end

  // ****************************************
  // Bus cycles
  // ****************************************
  // value on low lines, select on top lines
  task automatic wr(input logic [1:0] sel, input logic [9:0] val);
    @(posedge clk);
    cs0_n <= 1'b0;
    cs1 <= 1'b1;
    data_in <= {sel, val};
    wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    // Data held well past the rise so the synchronised copy is stable
    repeat (5) @(posedge clk);
    cs0_n <= 1'b1;
    cs1 <= 1'b0;
    data_in <= ~{sel, val};
    repeat (3) @(posedge clk);
  endtask

  // Read/write style: read pin strobes, write pin held low marks a write
  task automatic wrs(input logic [1:0] sel, input logic [9:0] val);
    @(posedge clk);
    cs0_n <= 1'b0;
    cs1 <= 1'b1;
    data_in <= {sel, val};
    wr_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (4) @(posedge clk);
    rd_n <= 1'b1;
    repeat (5) @(posedge clk);
    // Direction drops with the selects, so its rise is never taken as a strobe
    cs0_n <= 1'b1;
    cs1 <= 1'b0;
    wr_n <= 1'b1;
    data_in <= ~{sel, val};
    repeat (3) @(posedge clk);
  endtask

  task automatic rd(output logic [11:0] d);
    int n;
    d = 'x;
    @(posedge clk);
    cs0_n <= 1'b0;
    cs1 <= 1'b1;
    rd_n <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (data_oe !== 1'b1 && n < 12);
    if (data_oe === 1'b1) d = data_out;
    rd_n <= 1'b1;
    cs0_n <= 1'b1;
    cs1 <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (data_oe !== 1'b0 && n < 12);
    repeat (3) @(posedge clk);
  endtask
endmodule // acr_host
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Host model drives the bus; bench drives the converter core side.
// Notes: Expected codes are worked out here from the format and test rules.
`timescale 1ns/10ps
`default_nettype none
module testbench import acr_pkg::*;;
  logic clk = 1'b0;
  logic resetn, raw_valid, cs0_n, cs1, wr_n, rd_n, data_oe, sample_valid;
  logic [11:0] raw_code, data_in, data_out, sample_out, d, raw, want;
  logic ref_ext, sleep_ctl, input_pick_lo, input_pick_hi, pair_count_lo, pair_count_hi;
  logic autoscan_en, probe_volt_sel_lo, probe_volt_sel_hi, config_echo_en, offset_en;
  logic code_format_sel, strobe_style, soft_clear;
  logic [9:0] mseen, iseen;
  int mismatches = 0, samples_checked = 0, soft_cnt = 0, cyc = 0, f, p, k, q;
  localparam logic [11:0] CODES [3] = '{12'hfff, 12'h800, 12'h000};
  // Same three levels in twos complement: top, middle, bottom
  localparam logic [11:0] TWOS [3] = '{12'h7ff, 12'h000, 12'h800};

  assign mseen = {probe_volt_sel_hi, probe_volt_sel_lo, autoscan_en, pair_count_hi,
                  pair_count_lo, input_pick_hi, input_pick_lo, sleep_ctl, 1'b0, ref_ext};
  assign iseen = {config_echo_en, offset_en, code_format_sel, strobe_style, 6'h00};

  acr_bank i_acr_bank (.clk(clk), .resetn(resetn), .cs0_n(cs0_n), .cs1(cs1), .wr_n(wr_n),
    .rd_n(rd_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .raw_code(raw_code), .raw_valid(raw_valid), .sample_out(sample_out),
    .sample_valid(sample_valid), .ref_ext(ref_ext), .sleep_ctl(sleep_ctl),
    .input_pick_lo(input_pick_lo), .input_pick_hi(input_pick_hi),
    .pair_count_lo(pair_count_lo), .pair_count_hi(pair_count_hi), .autoscan_en(autoscan_en),
    .probe_volt_sel_lo(probe_volt_sel_lo), .probe_volt_sel_hi(probe_volt_sel_hi),
    .config_echo_en(config_echo_en), .offset_en(offset_en), .code_format_sel(code_format_sel),
    .strobe_style(strobe_style), .soft_clear(soft_clear));

  acr_host i_acr_host (.clk(clk), .data_out(data_out), .data_oe(data_oe), .cs0_n(cs0_n),
    .cs1(cs1), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in));

  always #2.5 clk = ~clk;

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cfg(input logic [9:0] m, input logic [9:0] i);
    chk("mode_fields", {2'h0, m & 10'h3fd}, {2'h0, mseen});
    chk("iface_fields", {2'h0, i & 10'h3c0}, {2'h0, iseen});
  endtask

  task automatic conv(input logic [11:0] r, input logic [11:0] e);
    @(posedge clk);
    raw_code <= r;
    raw_valid <= 1'b1;
    @(posedge clk);
    raw_valid <= 1'b0;
    #1;
    chk("sample_out", e, sample_out);
    chk("sample_valid", 12'h001, {11'h0, sample_valid});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    if (soft_clear === 1'b1) soft_cnt++;
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      results();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    resetn = 1'b0;
    raw_code = 12'h000;
    raw_valid = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    cfg(MODE_RST, IFACE_RST);
    chk("data_oe", 12'h000, {11'h0, data_oe});
    $display("test reset_values done");
    i_acr_host.wr(SEL_MODE, 10'h3cd);
    cfg(10'h3cd, 10'h000);
    i_acr_host.wr(SEL_MODE, 10'h1b0);
    cfg(10'h1b0, 10'h000);
    i_acr_host.wr(2'h2, 10'h004);
    i_acr_host.wr(2'h3, 10'h080);
    cfg(10'h1b0, 10'h000);
    $display("test mode_writes done");
    i_acr_host.wr(SEL_MODE, 10'h004);
    i_acr_host.wr(SEL_IFACE, 10'h200);
    cfg(10'h004, 10'h200);
    i_acr_host.rd(d);
    chk("echo_mode", {SEL_MODE, 10'h004}, d);
    i_acr_host.rd(d);
    chk("echo_iface", {SEL_IFACE, 10'h200}, d);
    $display("test sleep_echo done");
    for (f = 0; f < 2; f++) begin
      i_acr_host.wr(SEL_IFACE, {2'h0, f[0], 7'h00});
      for (p = 0; p < 4; p++) begin
        i_acr_host.wr(SEL_MODE, {p[1:0], 8'h20});
        for (k = 0; k < 3; k++) begin
          raw = CODES[k] ^ (12'h123 & {12{p != 0}});
          q = (p == 0) ? k : p - 1;
          want = f[0] ? TWOS[q] : CODES[q];
          conv(raw, want);
        end
      end
    end
    i_acr_host.rd(d);
    chk("read_sample", want, d);
    $display("test output_format done");
    i_acr_host.wr(SEL_IFACE, 10'h002);
    chk("soft_pulses", 12'h001, soft_cnt[11:0]);
    cfg(10'h320, 10'h000);
    i_acr_host.wr(SEL_IFACE, 10'h281);
    cfg(MODE_RST, IFACE_RST);
    chk("soft_pulses", 12'h002, soft_cnt[11:0]);
    $display("test reset_bits done");
    i_acr_host.wr(SEL_IFACE, 10'h140);
    cfg(MODE_RST, 10'h140);
    i_acr_host.wr(SEL_MODE, 10'h3cd);
    cfg(MODE_RST, 10'h140);
    i_acr_host.wrs(SEL_MODE, 10'h1b0);
    cfg(10'h1b0, 10'h140);
    i_acr_host.rd(d);
    chk("read_style", want, d);
    i_acr_host.wrs(SEL_IFACE, 10'h001);
    cfg(MODE_RST, IFACE_RST);
    $display("test strobe_style done");
    results();
  end
endmodule // testbench
`default_nettype wire
